// File: verilog/prw_monitor.sv
// Preset reference selection, trim, current limit and limit warning monitor.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module prw_monitor #(
    parameter logic [15:0] AMP_MAX = 16'h03E8  // Maximum output current, tenths of ampere.
) (
    // Clock and reset.
    input  wire logic                 mclk,
    input  wire logic                 rst_b,
    // APB slave.
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Digital input terminals, asynchronous.
    input  wire prw_pkg::prw_din_t    din,
    // Drive measurements and external references, same clock.
    input  wire prw_pkg::prw_meas_t   meas,
    input  wire logic signed [31:0]   ref_min,
    input  wire logic signed [31:0]   ref_max,
    input  wire logic signed [31:0]   ext_analog,
    input  wire logic signed [31:0]   ext_pulse,
    input  wire logic signed [31:0]   ext_serial,
    // Results.
    output logic signed [31:0]        ref_out,
    output logic      [15:0]          current_limit,
    output logic      [5:0]           warnings,
    output logic                      warn_dout,
    output logic                      warn_relay
);
    // Register storage.
    logic signed [15:0] preset [4];
    logic signed [15:0] trim_percentage;
    logic        [31:0] ctrl;
    logic        [15:0] under_amp_alert_level;
    logic        [15:0] over_amp_alert_level;
    logic        [15:0] under_speed_alert_level;
    logic        [15:0] over_speed_alert_level;
    logic signed [31:0] under_feedback_alert_level;
    logic signed [31:0] over_feedback_alert_level;

    logic               wr_en;
    logic               addr_ok;
    logic        [15:0] spd_cap;
    prw_pkg::prw_din_t  din_meta;
    prw_pkg::prw_din_t  din_sync;

    // Full scale of a percent field in hundredths; declared ahead of the clamp that uses it.
    localparam int PCT_MAX_W = 10000;

    // Saturate a signed word to the percent range.
    function automatic logic signed [15:0] clamp_pct(input logic [31:0] v, input logic lo_zero);
        logic signed [31:0] s;
        s = signed'(v);
        if (s > 32'(PCT_MAX_W)) begin
            clamp_pct = prw_pkg::PCT_MAX;
        end else if (lo_zero && s < 0) begin
            clamp_pct = 16'sh0000;
        end else if (s < -32'(PCT_MAX_W)) begin
            clamp_pct = prw_pkg::PCT_MIN;
        end else begin
            clamp_pct = s[15:0];
        end
    endfunction

    // Decode of the address map, shared by read and write paths.
    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a[1:0] == 2'h0) && (a <= prw_pkg::REF_OFS);
    endfunction

    // Terminal inputs are asynchronous, so each passes two flops first.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            din_meta <= '0;
            din_sync <= '0;
        end else begin
            din_meta <= din;
            din_sync <= din_meta;
        end
    end

    // Zero-wait APB: every access completes in its first access cycle.
    assign pready  = 1'b1;
    assign addr_ok = known_addr(paddr);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en   = psel && penable && pwrite && addr_ok;

    // The frequency cap depends on the selected range.
    assign spd_cap = (ctrl[prw_pkg::CTRL_RANGE_LSB+1]) ? prw_pkg::SPD_CAP_HIGH
                                                        : prw_pkg::SPD_CAP_LOW;

    // Preset registers; writes saturate to the signed percent range.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_preset
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    preset[gi] <= prw_pkg::PRESET_RST;
                end else if (wr_en && paddr == 8'(gi * 4)) begin
                    preset[gi] <= clamp_pct(pwdata, 1'b0);
                end
            end
        end
    endgenerate

    // Trim and control registers.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            trim_percentage <= prw_pkg::TRIM_RST;
            ctrl            <= prw_pkg::CTRL_RST;
            current_limit   <= prw_pkg::ILIM_RST;
        end else if (wr_en) begin
            if (paddr == prw_pkg::TRIM_OFS) begin
                trim_percentage <= clamp_pct(pwdata, 1'b1);
            end
            if (paddr == prw_pkg::CTRL_OFS) begin
                ctrl <= pwdata;
            end
            if (paddr == prw_pkg::ILIM_OFS) begin
                current_limit <= pwdata[15:0];
            end
        end
    end

    // Limit pairs; a write that would cross its partner is clipped to it.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            under_amp_alert_level      <= prw_pkg::AMP_LO_RST;
            over_amp_alert_level       <= AMP_MAX;
            under_speed_alert_level    <= prw_pkg::SPD_LO_RST;
            over_speed_alert_level     <= prw_pkg::SPD_HI_RST;
            under_feedback_alert_level <= prw_pkg::FB_LO_RST;
            over_feedback_alert_level  <= prw_pkg::FB_HI_RST;
        end else if (wr_en) begin
            case (paddr)
                prw_pkg::AMP_LO_OFS: begin
                    under_amp_alert_level <= (pwdata[15:0] > over_amp_alert_level)
                        ? over_amp_alert_level : pwdata[15:0];
                end
                prw_pkg::AMP_HI_OFS: begin
                    over_amp_alert_level <= (pwdata[15:0] > AMP_MAX) ? AMP_MAX
                        : (pwdata[15:0] < under_amp_alert_level) ? under_amp_alert_level
                        : pwdata[15:0];
                end
                prw_pkg::SPD_LO_OFS: begin
                    under_speed_alert_level <= (pwdata[15:0] > over_speed_alert_level)
                        ? over_speed_alert_level : pwdata[15:0];
                end
                prw_pkg::SPD_HI_OFS: begin
                    over_speed_alert_level <= (pwdata[15:0] > spd_cap) ? spd_cap
                        : (pwdata[15:0] < under_speed_alert_level) ? under_speed_alert_level
                        : pwdata[15:0];
                end
                prw_pkg::FB_LO_OFS: begin
                    under_feedback_alert_level <= (signed'(pwdata) > over_feedback_alert_level)
                        ? over_feedback_alert_level : signed'(pwdata);
                end
                prw_pkg::FB_HI_OFS: begin
                    over_feedback_alert_level <= (signed'(pwdata) < under_feedback_alert_level)
                        ? under_feedback_alert_level : signed'(pwdata);
                end
                default: begin
                end
            endcase
        end
    end

    // Reference path.
    logic        [1:0]  sel_code;
    logic signed [15:0] sel_pct;
    logic signed [31:0] ext_sum;
    logic signed [47:0] range_part;
    logic signed [47:0] rel_part;
    logic signed [31:0] preset_ref;
    logic signed [31:0] remote_ref;
    logic signed [47:0] trim_part;
    logic signed [31:0] next_ref;
    prw_pkg::prw_func_t func;

    assign func = prw_pkg::prw_func_t'(ctrl[prw_pkg::CTRL_FUNC_LSB +: 2]);

    // Code comes from the terminals unless software chose the serial bits.
    assign sel_code = ctrl[prw_pkg::CTRL_SER_SEL] ? ctrl[prw_pkg::CTRL_SER_CODE +: 2]
                    : {din_sync.preset_msb, din_sync.preset_lsb};
    assign sel_pct  = preset[sel_code];

    // Products are wide so no intermediate overflows; scale is 1/10000.
    always_comb begin
        ext_sum    = ext_analog + ext_pulse + ext_serial;
        range_part = 48'(sel_pct) * 48'(ref_max - ref_min) / 48'sd10000;
        rel_part   = 48'(sel_pct) * 48'(ext_sum) / 48'sd10000;
        case (func)
            prw_pkg::PRW_FN_REL: preset_ref = range_part[31:0] - range_part[31:0]
                                             + rel_part[31:0];
            prw_pkg::PRW_FN_EXT: preset_ref = din_sync.ext_sel ? range_part[31:0] : 32'sh0;
            default:             preset_ref = range_part[31:0];
        endcase
        // External/preset mode switches between the two sources outright.
        if (func == prw_pkg::PRW_FN_EXT && din_sync.ext_sel) begin
            remote_ref = preset_ref + ref_min;
        end else begin
            remote_ref = preset_ref + ext_sum + ref_min;
        end
        trim_part = 48'(remote_ref) * 48'(trim_percentage) / 48'sd10000;
        if (din_sync.catch_up && !din_sync.slow_down) begin
            next_ref = remote_ref + trim_part[31:0];
        end else if (din_sync.slow_down && !din_sync.catch_up) begin
            next_ref = remote_ref - trim_part[31:0];
        end else begin
            next_ref = remote_ref;
        end
    end

    // Registered reference output.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ref_out <= 32'sh0;
        end else begin
            ref_out <= next_ref;
        end
    end

    // Arming: warnings are live only after the frequency has reached the reference
    // while running, and drop the moment a stop begins.
    logic armed;
    logic reached;
    assign reached = (ref_out >= 0) && (32'(meas.freq) >= ref_out);
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            armed <= 1'b0;
        end else if (!din_sync.run || din_sync.stopping) begin
            armed <= 1'b0;
        end else if (reached) begin
            armed <= 1'b1;
        end
    end

    // Six comparisons each cycle; order is amp lo/hi, speed lo/hi, feedback lo/hi.
    logic [5:0] next_warn;
    always_comb begin
        next_warn[0] = meas.amps < under_amp_alert_level;
        next_warn[1] = meas.amps > over_amp_alert_level;
        next_warn[2] = meas.freq < under_speed_alert_level;
        next_warn[3] = meas.freq > over_speed_alert_level;
        next_warn[4] = meas.fbk < under_feedback_alert_level;
        next_warn[5] = meas.fbk > over_feedback_alert_level;
        if (!armed) begin
            next_warn = 6'h00;
        end
    end

    // Warnings and their routed outputs update together.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            warnings   <= 6'h00;
            warn_dout  <= 1'b0;
            warn_relay <= 1'b0;
        end else begin
            warnings   <= next_warn;
            warn_dout  <= |(next_warn & ctrl[prw_pkg::CTRL_DOUT_MASK +: 6]);
            warn_relay <= |(next_warn & ctrl[prw_pkg::CTRL_RELAY_MASK +: 6]);
        end
    end

    // Read mux; unmapped reads return zero with an error flag.
    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            case (paddr)
                prw_pkg::PRESET0_OFS: prdata = 32'(preset[0]);
                prw_pkg::PRESET1_OFS: prdata = 32'(preset[1]);
                prw_pkg::PRESET2_OFS: prdata = 32'(preset[2]);
                prw_pkg::PRESET3_OFS: prdata = 32'(preset[3]);
                prw_pkg::TRIM_OFS:    prdata = 32'(trim_percentage);
                prw_pkg::CTRL_OFS:    prdata = ctrl;
                prw_pkg::ILIM_OFS:    prdata = {16'h0000, current_limit};
                prw_pkg::AMP_LO_OFS:  prdata = {16'h0000, under_amp_alert_level};
                prw_pkg::AMP_HI_OFS:  prdata = {16'h0000, over_amp_alert_level};
                prw_pkg::SPD_LO_OFS:  prdata = {16'h0000, under_speed_alert_level};
                prw_pkg::SPD_HI_OFS:  prdata = {16'h0000, over_speed_alert_level};
                prw_pkg::FB_LO_OFS:   prdata = under_feedback_alert_level;
                prw_pkg::FB_HI_OFS:   prdata = over_feedback_alert_level;
                prw_pkg::STATUS_OFS:  prdata = {23'h0, armed, sel_code, warnings};
                prw_pkg::REF_OFS:     prdata = ref_out;
                default:              prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule // prw_monitor
`default_nettype wire

// File: verilog/prw_pkg.sv
// Package for the preset reference and warning monitor: register map, fields and defaults.
`default_nettype none
package prw_pkg;
    // Register byte offsets on the APB.
    localparam logic [7:0] PRESET0_OFS     = 8'h00;
    localparam logic [7:0] PRESET1_OFS     = 8'h04;
    localparam logic [7:0] PRESET2_OFS     = 8'h08;
    localparam logic [7:0] PRESET3_OFS     = 8'h0C;
    localparam logic [7:0] TRIM_OFS        = 8'h10;
    localparam logic [7:0] CTRL_OFS        = 8'h14;
    localparam logic [7:0] ILIM_OFS        = 8'h18;
    localparam logic [7:0] AMP_LO_OFS      = 8'h1C;
    localparam logic [7:0] AMP_HI_OFS      = 8'h20;
    localparam logic [7:0] SPD_LO_OFS      = 8'h24;
    localparam logic [7:0] SPD_HI_OFS      = 8'h28;
    localparam logic [7:0] FB_LO_OFS       = 8'h2C;
    localparam logic [7:0] FB_HI_OFS       = 8'h30;
    localparam logic [7:0] STATUS_OFS      = 8'h34;
    localparam logic [7:0] REF_OFS         = 8'h38;

    // Percent values are hundredths of a percent, signed 16 bit.
    localparam logic signed [15:0] PCT_MAX      = 16'sh2710;  // +100.00 %
    localparam logic signed [15:0] PCT_MIN      = -16'sh2710; // -100.00 %
    localparam logic signed [15:0] PRESET_RST   = 16'sh0000;
    localparam logic signed [15:0] TRIM_RST     = 16'sh0000;
    // Current limit in tenths of a percent of rated motor current.
    localparam logic [15:0] ILIM_RST            = 16'h0640;   // 160.0 %
    // Currents in tenths of an ampere; the maximum output current is a parameter.
    localparam logic [15:0] AMP_LO_RST          = 16'h0000;
    // Frequencies in tenths of a hertz.
    localparam logic [15:0] SPD_LO_RST          = 16'h0000;
    localparam logic [15:0] SPD_HI_RST          = 16'h0528;   // 132.0 Hz
    localparam logic [15:0] SPD_CAP_LOW         = 16'h0528;   // 132 Hz for ranges 0 and 1
    localparam logic [15:0] SPD_CAP_HIGH        = 16'h2710;   // 1000 Hz for ranges 2 and 3
    // Feedback in thousandths, signed 32 bit.
    localparam logic signed [31:0] FB_LO_RST    = -32'sh003D_0900; // -4000.000
    localparam logic signed [31:0] FB_HI_RST    = 32'sh003D_0900;  // 4000.000

    // Control register fields.
    localparam int CTRL_FUNC_LSB   = 0; // Reference function, 2 bits.
    localparam int CTRL_RANGE_LSB  = 2; // Frequency range, 2 bits.
    localparam int CTRL_SER_SEL    = 4; // Preset code taken from serial bits.
    localparam int CTRL_SER_CODE   = 5; // Serial preset code, 2 bits.
    localparam int CTRL_DOUT_MASK  = 8; // Six warning enables for digital output.
    localparam int CTRL_RELAY_MASK = 16; // Six warning enables for relay.
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    typedef enum logic [1:0] {PRW_FN_SUM, PRW_FN_REL, PRW_FN_EXT} prw_func_t;
    typedef enum logic {PRW_IDLE, PRW_ACCESS} prw_apb_state_t;

    // Inputs from the drive, grouped.
    typedef struct packed {
        logic               run;       // Start command active.
        logic               stopping;  // Stop command ramp in progress.
        logic               catch_up;
        logic               slow_down;
        logic               preset_msb;
        logic               preset_lsb;
        logic               ext_sel;   // Choose preset in external/preset mode.
    } prw_din_t;

    typedef struct packed {
        logic        [15:0] amps;      // Output current.
        logic        [15:0] freq;      // Output frequency.
        logic signed [31:0] fbk;       // Feedback.
    } prw_meas_t;
endpackage
`default_nettype wire

// File: tb/prw_terminals.sv
// Model of the digital input terminals that feed the monitor.
`timescale 1ns/1ps
`default_nettype none
module prw_terminals (
    // Clock and reset.
    input  wire logic              mclk,
    input  wire logic              rst_b,
    // Requested terminal levels and the pins driven toward the block.
    input  wire prw_pkg::prw_din_t req,
    output var  prw_pkg::prw_din_t din
);
    // Contacts settle one clock after a request; the block must sync them anyway.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            din <= '0;
        end else begin
            din <= req;
        end
    end
endmodule // prw_terminals
`default_nettype wire

// File: tb/prw_monitor_sva.sv
// Port-level concurrent checks for the preset reference and warning monitor.
`timescale 1ns/1ps
`default_nettype none
module prw_monitor_sva (
    // Clock, reset and bus.
    input wire logic               mclk,
    input wire logic               rst_b,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    // Terminals and results.
    input wire prw_pkg::prw_din_t  din,
    input wire logic [15:0]        current_limit,
    input wire logic [5:0]         warnings,
    input wire logic               warn_dout,
    input wire logic               warn_relay
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // The sync stages add lag, so quiet is only demanded after six cycles without run or six cycles of stopping.
    chk_idle_quiet: assert property (!din.run [*6] |-> warnings == 6'h00)
        else $error("warnings active while stopped");
    chk_stop_quiet: assert property (din.stopping [*6] |-> warnings == 6'h00)
        else $error("warnings active while stopping");
    chk_run_before_warn: assert property (warnings != 6'h00 |-> $past(din.run, 3) || $past(din.run, 4))
        else $error("warning without a run command");
    chk_pair_exclusive: assert property (!(warnings[0] && warnings[1])
        && !(warnings[2] && warnings[3]) && !(warnings[4] && warnings[5]))
        else $error("low and high warning together");
    chk_dout_cause: assert property (warn_dout |-> warnings != 6'h00 || $past(warnings) != 6'h00)
        else $error("digital output without warning");
    chk_relay_cause: assert property (warn_relay |-> warnings != 6'h00 || $past(warnings) != 6'h00)
        else $error("relay without warning");
    chk_limit_reset: assert property ($rose(rst_b) |-> current_limit == 16'h0640)
        else $error("current limit reset value wrong");
    chk_bus_error: assert property (psel && penable |-> pslverr == (paddr > 8'h38 || paddr[1:0] != 2'b00))
        else $error("slave error flag wrong");
    chk_rd_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_zero_wait: assert property (psel && !penable |=> pready)
        else $error("access phase stalled");

    cover property (warnings[0] && warn_dout);
    cover property (warn_relay);
    cover property (psel && penable && pslverr);
endmodule // prw_monitor_sva
bind prw_monitor prw_monitor_sva u_sva (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .din, .current_limit, .warnings, .warn_dout, .warn_relay);
`default_nettype wire

// File: tb/test_preset_reference_and_warning_monitor.sv
// Self-checking bench for the preset reference and warning monitor.
`timescale 1ns/1ps
`default_nettype none
module test_preset_reference_and_warning_monitor;
    localparam logic [15:0] AMP_MAX = 16'h03E8;
    logic               mclk, rst_b, psel, penable, pwrite, pready, pslverr, warn_dout, warn_relay;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rdata;
    logic signed [31:0] ref_min, ref_max, ext_analog, ext_pulse, ext_serial, ref_out;
    logic [15:0]        current_limit;
    logic [5:0]         warnings;
    prw_pkg::prw_din_t  req, din;
    prw_pkg::prw_meas_t meas;
    int                 mismatches, num_checks, seed_word;
    int                 pre[4];
    int                 trim_exp[4] = '{4000, 3000, 5000, 4000};

    // Free-running clock.
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    prw_monitor #(.AMP_MAX(AMP_MAX)) u_dut (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .din, .meas, .ref_min, .ref_max, .ext_analog,
        .ext_pulse, .ext_serial, .ref_out, .current_limit, .warnings, .warn_dout, .warn_relay);
    prw_terminals u_term (.mclk, .rst_b, .req, .din);

    // Count every comparison and report each mismatch at once.
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; read data is taken at the edge that sees pready.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rdata = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        cmp(rdata, e);
    endtask

    // Covers two sync stages, the terminal model and the output register.
    task automatic settle();
        repeat (8) @(posedge mclk);
    endtask

    function automatic logic [5:0] exp_warn(input prw_pkg::prw_meas_t m);
        return {m.fbk > 32'sd1000, m.fbk < -32'sd1000, m.freq > 16'd600, m.freq < 16'd100,
                m.amps > 16'd500, m.amps < 16'd100};
    endfunction

    task automatic summarize();
        if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // A hang counts as a failure.
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        summarize();
    end

    initial begin
        seed_word = $urandom(19845);
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {req, meas, ref_min, ext_analog, ext_pulse, ext_serial} = '0;
        ref_max = 32'sd0;
        mismatches = 0;
        num_checks = 0;
        rst_b = 1'b0;
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0000_0000);
        rd(prw_pkg::ILIM_OFS, 32'h0000_0640);
        cmp(32'(current_limit), 32'h0000_0640);
        rd(prw_pkg::AMP_LO_OFS, 32'h0000_0000);
        rd(prw_pkg::AMP_HI_OFS, 32'(AMP_MAX));
        rd(prw_pkg::SPD_LO_OFS, 32'h0000_0000);
        rd(prw_pkg::SPD_HI_OFS, 32'h0000_0528);
        rd(prw_pkg::FB_LO_OFS, 32'hFFC2_F700);
        rd(prw_pkg::FB_HI_OFS, 32'h003D_0900);
        rd(8'h3C, 32'h0000_0000);
        // Even presets keep the half-scale relative case exact.
        for (int i = 0; i < 3; i++) begin
            pre[i] = 2 * int'($urandom_range(10000)) - 10000;
            bus(1'b1, 8'(4 * i), 32'(pre[i]));
            rd(8'(4 * i), 32'(pre[i]));
        end
        pre[3] = -10000;
        bus(1'b1, prw_pkg::PRESET3_OFS, 32'(-20000));
        rd(prw_pkg::PRESET3_OFS, 32'(pre[3]));
        ref_min <= 32'sd1000;
        ref_max <= 32'sd11000;
        ext_analog <= 32'sd2000;
        ext_pulse <= 32'sd2000;
        ext_serial <= 32'sd1000;
        // Sum, then relative, over every preset code.
        for (int f = 0; f < 2; f++) begin
            bus(1'b1, prw_pkg::CTRL_OFS, 32'(f));
            for (int c = 0; c < 4; c++) begin
                req.preset_msb <= c[1];
                req.preset_lsb <= c[0];
                settle();
                cmp(ref_out, 32'(6000 + (f == 0 ? pre[c] : pre[c] / 2)));
            end
        end
        req.preset_msb <= 1'b0;
        req.preset_lsb <= 1'b0;
        bus(1'b1, prw_pkg::CTRL_OFS, 32'h0000_0070);
        settle();
        cmp(ref_out, 32'(6000 + pre[3]));
        // External/preset mode: the select input swaps preset for the external sum.
        bus(1'b1, prw_pkg::CTRL_OFS, 32'h0000_0002);
        req.ext_sel <= 1'b1;
        settle();
        cmp(ref_out, 32'(1000 + pre[0]));
        req.ext_sel <= 1'b0;
        settle();
        cmp(ref_out, 32'sd6000);
        bus(1'b1, prw_pkg::CTRL_OFS, 32'h0000_0000);
        bus(1'b1, prw_pkg::TRIM_OFS, 32'd2500);
        ext_analog <= 32'(3000 - pre[0]);
        ext_pulse <= 32'sd0;
        ext_serial <= 32'sd0;
        for (int k = 0; k < 4; k++) begin
            req.catch_up <= k[1];
            req.slow_down <= k[0];
            settle();
            cmp(ref_out, 32'(trim_exp[k]));
        end
        // Zero range and zero preset hold the resulting reference at ref_min.
        {ref_min, ref_max, ext_analog} <= '0;
        {req.catch_up, req.slow_down} <= 2'b00;
        bus(1'b1, prw_pkg::PRESET0_OFS, 32'h0000_0000);
        bus(1'b1, prw_pkg::AMP_HI_OFS, 32'd500);
        bus(1'b1, prw_pkg::AMP_LO_OFS, 32'd800);
        rd(prw_pkg::AMP_LO_OFS, 32'd500);
        bus(1'b1, prw_pkg::AMP_LO_OFS, 32'd100);
        bus(1'b1, prw_pkg::SPD_LO_OFS, 32'd100);
        bus(1'b1, prw_pkg::SPD_HI_OFS, 32'd20000);
        rd(prw_pkg::SPD_HI_OFS, 32'h0000_0528);
        bus(1'b1, prw_pkg::CTRL_OFS, 32'h0000_0008);
        bus(1'b1, prw_pkg::SPD_HI_OFS, 32'd20000);
        rd(prw_pkg::SPD_HI_OFS, 32'h0000_2710);
        bus(1'b1, prw_pkg::CTRL_OFS, 32'h0002_0100);
        bus(1'b1, prw_pkg::SPD_HI_OFS, 32'd600);
        bus(1'b1, prw_pkg::FB_LO_OFS, 32'(-1000));
        bus(1'b1, prw_pkg::FB_HI_OFS, 32'd1000);
        meas <= {16'd300, 16'd300, 32'sd0};
        req.run <= 1'b1;
        settle();
        for (int n = 0; n < 40; n++) begin
            meas.amps <= 16'($urandom_range(700));
            meas.freq <= 16'($urandom_range(800));
            meas.fbk <= 32'(int'($urandom_range(3000)) - 1500);
            settle();
            cmp(32'(warnings), 32'(exp_warn(meas)));
            cmp(32'(warn_dout), 32'(warnings[0]));
            cmp(32'(warn_relay), 32'(warnings[1]));
        end
        meas <= {16'd0, 16'd300, 32'sd0};
        req.stopping <= 1'b1;
        settle();
        cmp(32'(warnings), 32'h0000_0000);
        {req.run, req.stopping} <= 2'b00;
        ref_min <= 32'sd5000;
        settle();
        cmp(32'(warnings), 32'h0000_0000);
        req.run <= 1'b1;
        settle();
        cmp(32'(warnings), 32'h0000_0000);
        meas.freq <= 16'd5000;
        settle();
        cmp(32'(warnings), 32'h0000_0009);
        summarize();
    end
endmodule // test_preset_reference_and_warning_monitor
`default_nettype wire
